// ---- rtl/cls_defines.svh ----
// Constants of the cut-to-length shear sequencer: register offsets, bit positions,
// reset values and timing counts. Included by the package; the design files see it through that.
`ifndef CLS_DEFINES_SVH
`define CLS_DEFINES_SVH

// Timing: clock and common tick
`define CLS_CLK_NS 20
`define CLS_TICK_NS 1000000
`define CLS_TICK_CYC (`CLS_TICK_NS / `CLS_CLK_NS)

// Register word offsets
`define CLS_R_CTRL 5'h00
`define CLS_R_STAT 5'h01
`define CLS_R_PART 5'h02
`define CLS_R_KERF 5'h03
`define CLS_R_MINPART 5'h04
`define CLS_R_SHENC 5'h05
`define CLS_R_RES 5'h06
`define CLS_R_MINDIE 5'h07
`define CLS_R_MAXDIE 5'h08
`define CLS_R_VELREF 5'h09
`define CLS_R_TOL 5'h0A
`define CLS_R_MANDIE 5'h0B
`define CLS_R_SHORT 5'h0C
`define CLS_R_VSHORT 5'h0D
`define CLS_R_HOLES 5'h0E
`define CLS_R_HOLEPAST 5'h0F
`define CLS_R_NOHOLE 5'h10
`define CLS_R_HOLESPC 5'h11
`define CLS_R_CEPOINT 5'h12
`define CLS_R_CEOFF 5'h13
`define CLS_R_DUMPDLY 5'h14
`define CLS_R_DUMPDWL 5'h15
`define CLS_R_MISTCNT 5'h16
`define CLS_R_MISTDLY 5'h17
`define CLS_R_MISTDWL 5'h18
`define CLS_R_ACC 5'h19
`define CLS_NREG 26

// Control register bits
`define CLS_C_HOLE 0
`define CLS_C_CMF 1
`define CLS_C_NOCUT 2
`define CLS_C_ERRCLR 3

// Status register bits
`define CLS_S_RUN 0
`define CLS_S_WARN 1
`define CLS_S_EVEL 2
`define CLS_S_ENOHOLE 3
`define CLS_S_ETOL 4
`define CLS_S_EMINPART 5
`define CLS_S_HOLD 6

// Limits and reset values, distances in units of 0.00001 inch
`define CLS_KERF_MAX 32'h000F_4240
`define CLS_MINPART_MAX 32'h05F5_E0DC
`define CLS_SHENC_MAX 32'h3B9A_CA00
`define CLS_RST_HOLESPC 32'h0001_86A0
`define CLS_RST_RES 32'h0000_0064
`define CLS_RST_TOL 32'h0000_2710
`define CLS_RST_ZERO 32'h0000_0000

`endif

// ---- rtl/cls_pkg.sv ----
// Types shared by the shear sequencer files.
// Assumes cls_defines.svh sits beside it on the include path.
`include "cls_defines.svh"

package cls_pkg;

  typedef struct packed {
    logic enc_step;
    logic hole;
    logic sheet;
    logic dwell_end;
    logic run_req;
    logic manual_cut;
    logic job_change;
  } cls_sense_t;

  typedef struct packed {
    logic line_run;
    logic shear_fire;
    logic dump;
    logic mist;
    logic short_part;
    logic vshort_part;
    logic warn_change;
  } cls_act_t;

  typedef enum logic [1:0] {
    CLS_T_IDLE,
    CLS_T_DELAY,
    CLS_T_DWELL
  } cls_tmr_state_t;

endpackage

// ---- rtl/cls_pulse_timer.sv ----
// Delay-then-dwell output timer counted in common ticks.
// Assumes start is a one-cycle pulse and tick a one-cycle pulse per time unit.
`timescale 1ns/1ns

module cls_pulse_timer
  import cls_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Control
  input wire logic start,
  input wire logic tick,
  input wire logic [W-1:0] delay,
  input wire logic [W-1:0] dwell,
  // Output
  output logic out
);

  cls_tmr_state_t state_ff, nxt_state;
  logic [W-1:0] cnt_ff, nxt_cnt;
  logic out_ff;

  assign out = out_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      CLS_T_IDLE: begin
        if (start) begin
          nxt_cnt = '0;
          nxt_state = (delay == '0) ? CLS_T_DWELL : CLS_T_DELAY;
        end
      end
      CLS_T_DELAY: begin
        // Dwell timing begins the moment the output turns on
        if (tick) begin
          if (cnt_ff + 1'b1 >= delay) begin
            nxt_cnt = '0;
            nxt_state = CLS_T_DWELL;
          end else begin
            nxt_cnt = cnt_ff + 1'b1;
          end
        end
      end
      CLS_T_DWELL: begin
        if (dwell == '0) begin
          nxt_state = CLS_T_IDLE;
        end else if (tick) begin
          if (cnt_ff + 1'b1 >= dwell) begin
            nxt_state = CLS_T_IDLE;
          end else begin
            nxt_cnt = cnt_ff + 1'b1;
          end
        end
      end
      default: nxt_state = CLS_T_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_ff <= CLS_T_IDLE;
      cnt_ff <= '0;
      out_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      out_ff <= (nxt_state == CLS_T_DWELL) && (dwell != '0);
    end
  end

endmodule

// ---- rtl/cls_shear_seq.sv ----
// Cut-to-length shear sequencer: length tracking, flying-die cut window,
// coil-end halts, hole counting and dump/mist output timing.
// Assumes sensor inputs are synchronous to ref_clk; die position and line velocity
// arrive as binary words in 0.00001 inch and 0.00001 inch per tick.
//
// Function
// - After shear dwell ends, wait dump delay, then turn dump on and start dwell.
// - Dump output stays on exactly the dump dwell when the dump delay is nonzero, then turns off.
// - Count shear cycles; trigger mist at the programmed count; count zero disables.
// - Mist turns on after the mist delay measured from the shear dwell.
// - Mist stays on for the mist dwell, then turns off.
// - Continuous flow on: auto crop cut on every run entry.
// - Continuous flow off: no auto crop; manual shear works normally.
// - Material change pending: halt at changeover distance and warn the operator.
// - Standard mode: shear target nearer than coil-end offset postpones that halt until after the cut.
// - Kerf is added to every part length; kerf above 10.0000 inch refused.
// - Refuse to run parts below minimum part length, settable 0 to 999.99964 inch.
// - New coil loads minus shear-to-encoder distance, at most 10,000 inch.
// - Cut only past minimum die distance, and in tolerance in no-cut mode.
// - Line faster than the velocity assumed for minimum die: halt and error.
// - No-cut mode omits cut if out of tolerance at maximum die; in-tolerance there cuts.
// - Manual cuts when not running fire at the manual-cut die position.
// - In run, short and very-short outputs follow the length thresholds.
// - Hole mode target is the hole count plus distance past last hole.
// - Standard/hole mode change accepted only while the line is halted.
// - Hole mode halts if no hole within no-hole distance; zero disables.
// - Hole detections ignored until minimum spacing travelled; default 1 inch.
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ns

module cls_shear_seq
  import cls_pkg::*;
#(
  parameter int TICK_CYC = `CLS_TICK_CYC,
  parameter int TW = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Machine sensors
  input wire cls_sense_t sense,
  input wire logic [31:0] die_pos,
  input wire logic [31:0] line_vel,
  // Machine actuators
  output cls_act_t act
);

  // Configuration and status registers
  logic [31:0] cfg_ff [0:`CLS_NREG-1];
  logic [31:0] rdata_ff;
  logic [31:0] tick_cnt_ff;
  logic tick_ff;
  logic run_ff, nxt_run;
  logic signed [31:0] acc_ff, nxt_acc;
  logic [31:0] since_hole_ff, nxt_since_hole;
  logic [15:0] hole_cnt_ff;
  logic [31:0] tail_ff;
  logic [15:0] mist_cnt_ff;
  logic sheet_q_ff, hole_q_ff, run_req_q_ff;
  logic crop_ff, man_ff, die_ready_ff;
  logic postpone_ff, coil_done_ff;
  logic warn_ff, e_vel_ff, e_nohole_ff, e_tol_ff, e_minpart_ff;
  logic fire_ff, short_ff, vshort_ff;
  logic dump_on, mist_on;

  // Register fields
  wire [31:0] ctrl = cfg_ff[`CLS_R_CTRL];
  wire hole_mode = ctrl[`CLS_C_HOLE];
  wire cmf = ctrl[`CLS_C_CMF];
  wire nocut = ctrl[`CLS_C_NOCUT];
  wire [31:0] part_len = cfg_ff[`CLS_R_PART];
  wire [31:0] kerf = cfg_ff[`CLS_R_KERF];
  wire [31:0] min_part = cfg_ff[`CLS_R_MINPART];
  wire [31:0] res = cfg_ff[`CLS_R_RES];
  wire [31:0] tol = cfg_ff[`CLS_R_TOL];
  wire [31:0] mist_cnt_set = cfg_ff[`CLS_R_MISTCNT];

  // Register write acceptance
  wire wr_ctrl = reg_wr && (reg_addr == `CLS_R_CTRL);
  wire err_clr = wr_ctrl && reg_wdata[`CLS_C_ERRCLR];
  wire ro_addr = (reg_addr == `CLS_R_STAT) || (reg_addr == `CLS_R_ACC);
  wire kerf_bad = (reg_addr == `CLS_R_KERF) && (reg_wdata > `CLS_KERF_MAX);
  wire minp_bad = (reg_addr == `CLS_R_MINPART) && (reg_wdata > `CLS_MINPART_MAX);
  wire shenc_bad = (reg_addr == `CLS_R_SHENC) && (reg_wdata > `CLS_SHENC_MAX);
  wire wr_ok = reg_wr && (reg_addr < 5'(`CLS_NREG)) && !ro_addr
               && !kerf_bad && !minp_bad && !shenc_bad;
  // A mode change while running keeps the old mode; the CMF and no-cut bits still load
  wire [31:0] ctrl_wval = {28'h000_0000, 1'b0, reg_wdata[`CLS_C_NOCUT],
                           reg_wdata[`CLS_C_CMF],
                           run_ff ? hole_mode : reg_wdata[`CLS_C_HOLE]};

  function automatic logic [31:0] rst_val(input int idx);
    case (idx)
      `CLS_R_HOLESPC: rst_val = `CLS_RST_HOLESPC;
      `CLS_R_RES: rst_val = `CLS_RST_RES;
      `CLS_R_TOL: rst_val = `CLS_RST_TOL;
      default: rst_val = `CLS_RST_ZERO;
    endcase
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < `CLS_NREG; gi++) begin : g_cfg
      always_ff @(posedge ref_clk) begin
        if (!nrst) begin
          cfg_ff[gi] <= rst_val(gi);
        end else if (wr_ok && (reg_addr == 5'(gi))) begin
          cfg_ff[gi] <= (gi == `CLS_R_CTRL) ? ctrl_wval : reg_wdata;
        end
      end
    end
  endgenerate

  // Common time base for every delay and dwell
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (tick_cnt_ff == 32'(TICK_CYC - 1));
      tick_cnt_ff <= (tick_cnt_ff == 32'(TICK_CYC - 1)) ? '0 : tick_cnt_ff + 1'b1;
    end
  end

  // Edges of sensor levels
  wire sheet_rise = sense.sheet && !sheet_q_ff;
  wire hole_rise = sense.hole && !hole_q_ff;
  wire run_entry = nxt_run && !run_ff;

  // Part targets with kerf folded in
  wire [31:0] target = part_len + kerf;
  wire signed [31:0] diff = acc_ff - $signed(target);
  wire [31:0] diff_abs = diff[31] ? 32'(-diff) : 32'(diff);
  wire part_short = part_len < min_part;

  // Hole acceptance and hole-mode target
  wire hole_ok = hole_mode && hole_rise && (since_hole_ff >= cfg_ff[`CLS_R_HOLESPC]);
  wire hole_reach = (hole_cnt_ff >= cfg_ff[`CLS_R_HOLES][15:0])
                    && (hole_cnt_ff != 16'h0000)
                    && (since_hole_ff >= cfg_ff[`CLS_R_HOLEPAST]);
  wire len_reach = acc_ff >= $signed(target - tol);
  wire in_tol = hole_mode || (diff_abs <= tol);

  // Flying-die cut window
  wire past_min = die_pos >= cfg_ff[`CLS_R_MINDIE];
  wire at_max = die_pos >= cfg_ff[`CLS_R_MAXDIE];
  wire cut_arm = run_ff && die_ready_ff && !crop_ff && (hole_mode ? hole_reach : len_reach);
  wire fire_auto = cut_arm && past_min && (!nocut || in_tol);
  wire omit = cut_arm && nocut && at_max && !in_tol && !fire_auto;
  wire fire_crop = run_ff && crop_ff && die_ready_ff && past_min;
  wire fire_man = !run_ff && man_ff && die_ready_ff
                  && (die_pos >= cfg_ff[`CLS_R_MANDIE]);
  wire fire = fire_auto || fire_crop || fire_man;

  // Coil-end changeover
  wire signed [31:0] remain = $signed(target) - acc_ff;
  wire ce_reach = run_ff && sense.job_change && !coil_done_ff
                  && (tail_ff >= cfg_ff[`CLS_R_CEPOINT]);
  wire ce_near = (remain > 0) && (remain < $signed(cfg_ff[`CLS_R_CEOFF])) && !hole_mode;
  wire halt_chg = (ce_reach && !ce_near) || (postpone_ff && fire_auto);

  // Line faults
  wire halt_vel = run_ff && (line_vel > cfg_ff[`CLS_R_VELREF]);
  wire halt_nohole = run_ff && hole_mode && (cfg_ff[`CLS_R_NOHOLE] != 32'h0000_0000)
                     && (since_hole_ff > cfg_ff[`CLS_R_NOHOLE]);
  wire halt = halt_chg || halt_vel || halt_nohole;

  // Run control: entry refused while the part is under the minimum length
  always_comb begin
    nxt_run = run_ff;
    if (halt || !sense.run_req) begin
      nxt_run = 1'b0;
    end else if (sense.run_req && !run_req_q_ff && !part_short) begin
      nxt_run = 1'b1;
    end
  end

  // Length accumulator
  always_comb begin
    nxt_acc = acc_ff;
    if (sheet_rise) begin
      nxt_acc = -$signed(cfg_ff[`CLS_R_SHENC]);
    end else begin
      if (fire_crop) begin
        nxt_acc = '0;
      end else if (fire_auto || omit) begin
        nxt_acc = acc_ff - $signed(target);
      end
      if (sense.enc_step) begin
        nxt_acc = nxt_acc + $signed(res);
      end
    end
  end

  // Distance since the last accepted hole, saturating
  always_comb begin
    nxt_since_hole = since_hole_ff;
    if (hole_ok) begin
      nxt_since_hole = '0;
    end else if (sense.enc_step && (since_hole_ff <= 32'hFFFF_FFFF - res)) begin
      nxt_since_hole = since_hole_ff + res;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      run_ff <= 1'b0;
      acc_ff <= '0;
      since_hole_ff <= '0;
      sheet_q_ff <= 1'b0;
      hole_q_ff <= 1'b0;
      run_req_q_ff <= 1'b0;
    end else begin
      run_ff <= nxt_run;
      acc_ff <= nxt_acc;
      since_hole_ff <= nxt_since_hole;
      sheet_q_ff <= sense.sheet;
      hole_q_ff <= sense.hole;
      run_req_q_ff <= sense.run_req;
    end
  end

  // Hole count: restarts after each cut so the next target counts afresh
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      hole_cnt_ff <= '0;
    end else if (fire || omit || !hole_mode) begin
      hole_cnt_ff <= hole_ok ? 16'h0001 : 16'h0000;
    end else if (hole_ok && (hole_cnt_ff != 16'hFFFF)) begin
      hole_cnt_ff <= hole_cnt_ff + 1'b1;
    end
  end

  // Cut requests and die readiness; the die must come back under minimum
  // before it may fire again, so one stroke never cuts twice
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      crop_ff <= 1'b0;
      man_ff <= 1'b0;
      die_ready_ff <= 1'b0;
    end else begin
      if (run_entry) begin
        crop_ff <= cmf;
      end else if (fire_crop || !run_ff) begin
        crop_ff <= 1'b0;
      end
      if (sense.manual_cut && !run_ff) begin
        man_ff <= 1'b1;
      end else if (fire_man || run_ff) begin
        man_ff <= 1'b0;
      end
      if (fire || omit) begin
        die_ready_ff <= 1'b0;
      end else if (!past_min) begin
        die_ready_ff <= 1'b1;
      end
    end
  end

  // Coil tail distance: material travelled since the sheet sensor went clear
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tail_ff <= '0;
      coil_done_ff <= 1'b0;
      postpone_ff <= 1'b0;
    end else begin
      if (sense.sheet) begin
        tail_ff <= '0;
      end else if (sense.enc_step && (tail_ff <= 32'hFFFF_FFFF - res)) begin
        tail_ff <= tail_ff + res;
      end
      if (sense.sheet) begin
        coil_done_ff <= 1'b0;
      end else if (ce_reach) begin
        coil_done_ff <= 1'b1;
      end
      if (ce_reach && ce_near) begin
        postpone_ff <= 1'b1;
      end else if (fire_auto || !run_ff) begin
        postpone_ff <= 1'b0;
      end
    end
  end

  // Sticky flags: a new event in the clearing cycle wins
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      warn_ff <= 1'b0;
      e_vel_ff <= 1'b0;
      e_nohole_ff <= 1'b0;
      e_tol_ff <= 1'b0;
      e_minpart_ff <= 1'b0;
    end else begin
      warn_ff <= halt_chg || (warn_ff && !err_clr);
      e_vel_ff <= halt_vel || (e_vel_ff && !err_clr);
      e_nohole_ff <= halt_nohole || (e_nohole_ff && !err_clr);
      e_tol_ff <= omit || (e_tol_ff && !err_clr);
      e_minpart_ff <= (sense.run_req && !run_req_q_ff && part_short)
                      || (e_minpart_ff && !err_clr);
    end
  end

  // Mist shear-cycle counter; zero setting keeps the feature off
  wire mist_en = mist_cnt_set != 32'h0000_0000;
  wire mist_trig = sense.dwell_end && mist_en
                   && ({16'h0000, mist_cnt_ff} + 32'h0000_0001 >= mist_cnt_set);
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      mist_cnt_ff <= '0;
    end else if (!mist_en || mist_trig) begin
      mist_cnt_ff <= '0;
    end else if (sense.dwell_end) begin
      mist_cnt_ff <= mist_cnt_ff + 1'b1;
    end
  end

  cls_pulse_timer #(.W(TW)) u_dump (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .start(sense.dwell_end),
    .tick(tick_ff),
    .delay(cfg_ff[`CLS_R_DUMPDLY][TW-1:0]),
    .dwell(cfg_ff[`CLS_R_DUMPDWL][TW-1:0]),
    .out(dump_on)
  );

  cls_pulse_timer #(.W(TW)) u_mist (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .start(mist_trig),
    .tick(tick_ff),
    .delay(cfg_ff[`CLS_R_MISTDLY][TW-1:0]),
    .dwell(cfg_ff[`CLS_R_MISTDWL][TW-1:0]),
    .out(mist_on)
  );

  // Registered outputs
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      fire_ff <= 1'b0;
      short_ff <= 1'b0;
      vshort_ff <= 1'b0;
    end else begin
      fire_ff <= fire;
      short_ff <= nxt_run && (target <= cfg_ff[`CLS_R_SHORT]);
      vshort_ff <= nxt_run && (target <= cfg_ff[`CLS_R_VSHORT]);
    end
  end

  assign act.line_run = run_ff;
  assign act.shear_fire = fire_ff;
  assign act.dump = dump_on;
  assign act.mist = mist_on;
  assign act.short_part = short_ff;
  assign act.vshort_part = vshort_ff;
  assign act.warn_change = warn_ff;

  // Register read, data in the cycle after the strobe
  wire [31:0] status = {25'h000_0000, postpone_ff, e_minpart_ff, e_tol_ff,
                        e_nohole_ff, e_vel_ff, warn_ff, run_ff};
  wire [31:0] rd_mux = (reg_addr == `CLS_R_STAT) ? status :
                       (reg_addr == `CLS_R_ACC) ? acc_ff :
                       (reg_addr < 5'(`CLS_NREG)) ? cfg_ff[reg_addr] : 32'h0000_0000;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end
  assign reg_rdata = rdata_ff;

endmodule

// ---- test/cls_machine.sv ----
// Machine model: encoder, sheet and hole sensors, shear stroke, flying die.
// Assumes the controller drives act as registered levels on ref_clk.
`timescale 1ns/1ns

module cls_machine
  import cls_pkg::*;
#(
  parameter int DWELL_CYC = 6,
  parameter int DIE_STEP = 1000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Controller side
  input wire cls_act_t act,
  input wire logic kick,
  // Sensors
  output logic enc_step,
  output logic dwell_end,
  output logic [31:0] die_pos,
  output logic sheet,
  output logic hole
);
  logic [1:0] div_ff;
  int dwell_ff;

  // Plain stock that never runs out: no holes, no new coil
  assign hole = 1'b0;
  assign sheet = 1'b1;

  always @(posedge ref_clk) begin
    if (!nrst) begin
      div_ff <= 2'h0;
      dwell_ff <= 0;
      enc_step <= 1'b0;
      dwell_end <= 1'b0;
      die_pos <= 32'h0;
    end else begin
      div_ff <= div_ff + 2'h1;
      enc_step <= act.line_run && div_ff == 2'h3;
      dwell_end <= kick || dwell_ff == 1;
      if (act.shear_fire)
        dwell_ff <= DWELL_CYC;
      else if (dwell_ff > 0)
        dwell_ff <= dwell_ff - 1;
      // Die rides with the sheet until the shear fires, holds through the stroke, returns to zero at its end
      if (dwell_ff == 1 || !act.line_run)
        die_pos <= 32'h0;
      else if (dwell_ff == 0 && die_pos < 32'h0004_93E0)
        die_pos <= die_pos + DIE_STEP;
    end
  end
endmodule

// ---- test/cls_shear_seq_bench.sv ----
// Self-checking bench of the shear sequencer and machine model.
// Assumes a short tick of 5 clocks so timer figures stay small.
`timescale 1ns/1ns

module cls_shear_seq_bench;
  import cls_pkg::*;

  typedef struct {
    logic [4:0] addr;
    logic wr;
    logic [31:0] wdata;
    logic [31:0] exp;
  } cls_row_t;

  logic ref_clk, nrst, reg_wr, reg_rd, kick, run_req, enc_step, dwell_end, sheet, hole;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, line_vel, die_pos, rdata;
  cls_act_t act;
  cls_sense_t sense;
  int n_fail = 0;
  int total_checks = 0;
  int f_dump, n_dump, f_mist, n_mist, fires;
  cls_row_t rows [0:15] = '{
    '{5'h06, 1'b0, 32'h0, 32'h0000_0064},
    '{5'h11, 1'b0, 32'h0, 32'h0001_86A0},
    '{5'h0A, 1'b0, 32'h0, 32'h0000_2710},
    '{5'h01, 1'b0, 32'h0, 32'h0},
    '{5'h03, 1'b1, 32'h000F_4240, 32'h000F_4240},
    '{5'h03, 1'b1, 32'h000F_4241, 32'h000F_4240},
    '{5'h04, 1'b1, 32'h05F5_E0DC, 32'h05F5_E0DC},
    '{5'h04, 1'b1, 32'h05F5_E0DD, 32'h05F5_E0DC},
    '{5'h05, 1'b1, 32'h3B9A_CA00, 32'h3B9A_CA00},
    '{5'h05, 1'b1, 32'h3B9A_CA01, 32'h3B9A_CA00},
    '{5'h01, 1'b1, 32'h0000_00FF, 32'h0},
    '{5'h1A, 1'b1, 32'h0000_1234, 32'h0},
    '{5'h03, 1'b1, 32'h0, 32'h0},
    '{5'h04, 1'b1, 32'h0, 32'h0},
    '{5'h05, 1'b1, 32'h0, 32'h0},
    '{5'h11, 1'b1, 32'h0000_C350, 32'h0000_C350}
  };

  assign sense = '{enc_step, hole, sheet, dwell_end, run_req, 1'b0, 1'b0};

  cls_machine i_machine (.ref_clk(ref_clk), .nrst(nrst), .act(act), .kick(kick),
    .enc_step(enc_step), .dwell_end(dwell_end), .die_pos(die_pos), .sheet(sheet),
    .hole(hole));

  cls_shear_seq #(.TICK_CYC(5)) i_dut (.ref_clk(ref_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sense(sense), .die_pos(die_pos), .line_vel(line_vel),
    .act(act));

  task automatic check_word(input string what, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_range(input string what, input int lo, hi, got);
    total_checks++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic reg_write(input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Data stand only the cycle after the strobe
  task automatic reg_read(input logic [4:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic set_run(input logic v);
    @(posedge ref_clk);
    run_req <= v;
  endtask

  // One shear dwell, then time dump and mist
  task automatic kick_watch(output int fd, nd, fm, nm);
    fd = -1;
    nd = 0;
    fm = -1;
    nm = 0;
    @(posedge ref_clk);
    kick <= 1'b1;
    @(posedge ref_clk);
    kick <= 1'b0;
    for (int i = 2; i < 60; i++) begin
      @(posedge ref_clk);
      #1;
      if (act.dump === 1'b1 && fd < 0)
        fd = i;
      if (act.mist === 1'b1 && fm < 0)
        fm = i;
      nd += (act.dump === 1'b1);
      nm += (act.mist === 1'b1);
    end
  endtask

  task automatic run_count(output int n);
    set_run(1'b1);
    n = 0;
    repeat (200) begin
      @(posedge ref_clk);
      #1;
      n += (act.shear_fire === 1'b1);
    end
    check_word("running", 32'h1, 32'(act.line_run));
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // The run takes about 760 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    results();
  end

  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    kick = 1'b0;
    run_req = 1'b0;
    reg_addr = 5'h0;
    reg_wdata = 32'h0;
    line_vel = 32'h0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    #1;
    check_word("reset act", 32'h0, {25'h0, act});
    foreach (rows[i]) begin
      if (rows[i].wr)
        reg_write(rows[i].addr, rows[i].wdata);
      reg_read(rows[i].addr, rdata);
      check_word("register", rows[i].exp, rdata);
    end
    $display("table done");
    reg_write(5'h14, 32'h2);
    reg_write(5'h15, 32'h3);
    reg_write(5'h16, 32'h2);
    reg_write(5'h17, 32'h1);
    reg_write(5'h18, 32'h2);
    for (int k = 0; k < 4; k++) begin
      if (k == 2)
        reg_write(5'h16, 32'h0);
      kick_watch(f_dump, n_dump, f_mist, n_mist);
      check_range("dump start", 7, 15, f_dump);
      check_word("dump on", 32'h0000_000F, n_dump);
      check_word("mist on", (k == 1) ? 32'h0000_000A : 32'h0, n_mist);
      if (k == 1)
        check_range("mist start", 2, 10, f_mist);
    end
    $display("timers done");
    reg_write(5'h02, 32'h0000_03E8);
    reg_write(5'h04, 32'h0000_07D0);
    set_run(1'b1);
    repeat (5) @(posedge ref_clk);
    #1;
    check_word("run refused", 32'h0, 32'(act.line_run));
    reg_read(5'h01, rdata);
    check_word("min part flag", 32'h1, 32'(rdata[5]));
    set_run(1'b0);
    reg_write(5'h00, 32'h0000_0008);
    reg_write(5'h04, 32'h0);
    $display("min part done");
    reg_write(5'h02, 32'h0007_A120);
    reg_write(5'h07, 32'h0000_C350);
    reg_write(5'h09, 32'h0000_03E8);
    reg_write(5'h0C, 32'h0009_27C0);
    reg_write(5'h00, 32'h0000_0002);
    run_count(fires);
    check_word("crop cuts", 32'h1, fires);
    check_word("short part", 32'h1, 32'(act.short_part));
    check_word("very short", 32'h0, 32'(act.vshort_part));
    reg_write(5'h00, 32'h0000_0003);
    reg_read(5'h00, rdata);
    check_word("mode locked", 32'h0, 32'(rdata[0]));
    set_run(1'b0);
    repeat (4) @(posedge ref_clk);
    reg_write(5'h00, 32'h0);
    $display("crop run done");
    run_count(fires);
    check_word("no crop cut", 32'h0, fires);
    @(posedge ref_clk);
    line_vel <= 32'h0000_03E9;
    repeat (4) @(posedge ref_clk);
    #1;
    check_word("overspeed halt", 32'h0, 32'(act.line_run));
    reg_read(5'h01, rdata);
    check_word("overspeed flag", 32'h1, 32'(rdata[2]));
    @(posedge ref_clk);
    line_vel <= 32'h0;
    set_run(1'b0);
    $display("plain run done");
    results();
  end
endmodule

// ---- test/cls_shear_seq_sva.sv ----
// Port checker of the shear sequencer.
// Assumes registers change only through its register port.
`timescale 1ns/1ns

module cls_shear_seq_chk
  import cls_pkg::*;
#(
  parameter int TICK_CYC = 5,
  parameter int TW = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Machine side
  input wire cls_sense_t sense,
  input wire logic [31:0] die_pos,
  input wire logic [31:0] line_vel,
  input wire cls_act_t act
);
  // Only unlimited registers are read back from this copy
  logic [31:0] shadow_ff [0:31];
  logic [31:0] dump_len_ff, mist_len_ff, since_dwell_ff;
  wire [31:0] dump_dly = shadow_ff[5'h14][TW-1:0] * TICK_CYC;
  wire [31:0] dump_dwl = shadow_ff[5'h15][TW-1:0] * TICK_CYC;
  wire [31:0] mist_dwl = shadow_ff[5'h18][TW-1:0] * TICK_CYC;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      for (int i = 0; i < 32; i++)
        shadow_ff[i] <= 32'h0;
      dump_len_ff <= 32'h0;
      mist_len_ff <= 32'h0;
      since_dwell_ff <= 32'h0;
    end else begin
      if (reg_wr)
        shadow_ff[reg_addr] <= reg_wdata;
      dump_len_ff <= act.dump ? dump_len_ff + 32'h1 : 32'h0;
      mist_len_ff <= act.mist ? mist_len_ff + 32'h1 : 32'h0;
      since_dwell_ff <= sense.dwell_end ? 32'h0 : since_dwell_ff + 32'h1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("stray read data");
  fire_window_a: assert property (act.shear_fire && $past(act.line_run) |->
    $past(die_pos) >= shadow_ff[5'h07])
    else $error("cut before minimum die");
  fire_pulse_a: assert property (act.shear_fire |=> !act.shear_fire)
    else $error("long shear pulse");
  dump_start_a: assert property ($rose(act.dump) |->
    since_dwell_ff + TICK_CYC >= dump_dly && since_dwell_ff <= dump_dly + 3)
    else $error("dump delay wrong");
  dump_len_a: assert property ($fell(act.dump) |-> dump_len_ff == dump_dwl)
    else $error("dump dwell wrong");
  mist_len_a: assert property ($fell(act.mist) |-> mist_len_ff == mist_dwl)
    else $error("mist dwell wrong");
  mist_off_a: assert property (shadow_ff[5'h16] == 32'h0 |-> !act.mist)
    else $error("mist while disabled");
  vel_halt_a: assert property (act.line_run && line_vel > shadow_ff[5'h09] |->
    ##[1:3] !act.line_run)
    else $error("no overspeed halt");
  short_run_a: assert property (!act.line_run && !$past(act.line_run) &&
    !$past(act.line_run, 2) |-> !act.short_part && !act.vshort_part)
    else $error("short output idle");
endmodule

bind cls_shear_seq cls_shear_seq_chk #(.TICK_CYC(TICK_CYC), .TW(TW)) i_chk (
  .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sense(sense),
  .die_pos(die_pos), .line_vel(line_vel), .act(act));
